// file: logic/dcr_cfg.svh
// Offsets, field positions, reset values and counts of the register bank.
// Assumes inclusion by each design file that uses its macros; guarded against repeats.
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
`define DCR_ADDR_PRIMARY 5'h00
`define DCR_ADDR_ANALOG 5'h01
`define DCR_ADDR_SCALE 5'h02
`define DCR_ADDR_RAMP 5'h03
`define DCR_ADDR_FREQ 5'h04
`define DCR_ADDR_PHASE 5'h05
`define DCR_RST_PRIMARY 32'h00000000
`define DCR_RST_ANALOG 24'h000000
`define DCR_RST_SCALE 16'h0000
`define DCR_RST_RAMP 8'h00
`define DCR_RST_FREQ 32'h00000000
`define DCR_RST_PHASE 14'h0000
`define DCR_RST_LFSR 16'hACE1
`define DCR_B_RAMP_LOAD 26
`define DCR_B_OSK_EN 25
`define DCR_B_OSK_AUTO 24
`define DCR_B_AUTO_SYNC 23
`define DCR_B_SW_SYNC 22
`define DCR_B_AMP_DITH 20
`define DCR_B_PH_DITH_HI 19
`define DCR_B_PH_DITH_LO 16
`define DCR_B_AUTO_CLR 13
`define DCR_B_SINE 12
`define DCR_B_CLR_ACC 10
`define DCR_B_IN_ONLY 9
`define DCR_B_LSB_FIRST 8
`define DCR_B_DIG_PD 7
`define DCR_B_DAC_PD 5
`define DCR_B_CLKIN_PD 4
`define DCR_B_PD_MODE 3
`define DCR_B_SYNC_DIS 1
`define DCR_B2_HW_SYNC 10
`define DCR_B2_PRIME_DIS 8
`define DCR_SCALE_FULL 14'h3FFF
`define DCR_SYNC_STEP 2'h1
`define DCR_SYNC_ADV 2'h2
`endif

// file: logic/dcr_pkg.sv
// Types shared by the register bank and its serial port.
// Assumes dcr_cfg.svh for the register offsets.
`include "dcr_cfg.svh"
package dcr_pkg;
	typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA} dcr_sp_state_t;
	function automatic logic [2:0] dcr_reg_bytes(input logic [4:0] addr);
		if (addr == `DCR_ADDR_PRIMARY || addr == `DCR_ADDR_FREQ) begin
			return 3'h4;
		end else if (addr == `DCR_ADDR_ANALOG) begin
			return 3'h3;
		end else if (addr == `DCR_ADDR_SCALE || addr == `DCR_ADDR_PHASE) begin
			return 3'h2;
		end
		return 3'h1;
	endfunction
endpackage

// file: logic/dcr_if.sv
// Register access carrier between the bank and its serial port.
// Assumes one ref_clk domain on both ends.
interface dcr_if;
	logic wr_stb;
	logic [4:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic lsb_first;
	logic three_wire;
	modport regs(input wr_stb, addr, wdata, output rdata, lsb_first, three_wire);
	modport port(output wr_stb, addr, wdata, input rdata, lsb_first, three_wire);
endinterface

// file: logic/dcr_sync2.sv
// Two-flop synchroniser for asynchronous pins.
// Assumes each bit is an independent level.
module dcr_sync2 #(parameter int WIDTH = 1) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: logic/dcr_serial.sv
// Serial control port: instruction byte, then register data in either bit order.
// Assumes synchronised pins and SCLK below an eighth of ref_clk.
`include "dcr_cfg.svh"
module dcr_serial
	import dcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic sclk_s,
	input wire logic cs_n_s,
	input wire logic sdio_s,
	output logic sdio_o,
	output logic sdio_oe,
	output logic sdo_o,
	output logic sdo_oe,
	dcr_if.port bus
);
	dcr_sp_state_t state_r;
	logic sclk_d_r;
	logic [5:0] cnt_r;
	logic [7:0] instr_r;
	logic [31:0] shift_r;
	logic [31:0] wdata_r;
	logic out_r;
	logic wr_r;
	logic rise;
	logic fall;
	logic rd;
	logic [5:0] last;
	logic [5:0] bidx;
	logic [31:0] shift_nxt;
	assign rise = sclk_s & ~sclk_d_r;
	assign fall = ~sclk_s & sclk_d_r;
	assign rd = instr_r[7];
	assign last = (state_r == SP_INSTR) ? 6'h07 : {dcr_reg_bytes(instr_r[4:0]), 3'h0} - 6'h01;
	assign bidx = bus.lsb_first ? cnt_r : last - cnt_r; // see (RULE11)
	assign shift_nxt = (shift_r & ~(32'h00000001 << bidx)) | ({31'h0, sdio_s} << bidx);
	assign bus.wr_stb = wr_r;
	assign bus.wdata = wdata_r;
	assign bus.addr = instr_r[4:0];
	// Read data leave on SDIO in two-wire mode, on SDO in three-wire mode
	assign sdio_oe = (state_r == SP_DATA) & rd & ~bus.three_wire; // see (RULE10)
	assign sdo_oe = (state_r == SP_DATA) & rd & bus.three_wire;
	assign sdio_o = out_r;
	assign sdo_o = out_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= SP_IDLE;
			sclk_d_r <= 1'b0;
			cnt_r <= 6'h00;
			instr_r <= 8'h00;
			shift_r <= 32'h00000000;
			wdata_r <= 32'h00000000;
			out_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
			wr_r <= 1'b0;
			if (cs_n_s) begin
				state_r <= SP_IDLE;
				cnt_r <= 6'h00;
			end else begin
				case (state_r)
					SP_IDLE: begin
						state_r <= SP_INSTR;
						shift_r <= 32'h00000000;
					end
					SP_INSTR: if (rise) begin
						cnt_r <= (cnt_r == last) ? 6'h00 : cnt_r + 6'h01;
						shift_r <= (cnt_r == last) ? 32'h00000000 : shift_nxt;
						if (cnt_r == last) begin
							instr_r <= shift_nxt[7:0];
							state_r <= SP_DATA;
						end
					end
					SP_DATA: if (rise) begin
						cnt_r <= (cnt_r == last) ? 6'h00 : cnt_r + 6'h01;
						shift_r <= (cnt_r == last) ? 32'h00000000 : shift_nxt;
						if (cnt_r == last) begin
							wr_r <= ~rd;
							wdata_r <= shift_nxt;
							state_r <= SP_INSTR;
						end
					end else if (fall && rd) begin
						out_r <= bus.rdata[bidx[4:0]];
					end
					default: state_r <= SP_IDLE;
				endcase
			end
		end
	end
endmodule

// file: logic/dcr_top.sv
// Control register bank of a direct digital synthesizer and the core logic it steers.
// Assumes pins are asynchronous to ref_clk, the system clock.
// How it works
// (RULE1) Ramp timer reloads at one, optionally on transfer
// (RULE2) Keying disabled bypasses amplitude scaling entirely
// (RULE3) Keying mode bit picks manual or automatic
// (RULE4) Automatic sync active only while bit set
// (RULE5) Software sync advances clock once, self-clears
// (RULE6) Dither bits enable amplitude and phase dithering
// (RULE7) Auto-clear zeroes accumulator on each transfer; the code skips it while halt is set
// (RULE8) Waveform bit selects cosine or sine
// (RULE9) Clear bit holds accumulator at zero
// (RULE10) Input-only bit selects three-wire serial mode
// (RULE11) Bit-order bit accepts least significant first
// (RULE12) Digital power-down stops core, keeps serial port
// (RULE13) Converter and clock-input power-down bits
// (RULE14) Power-down pin mode: digital only or all
// (RULE15) Sync clock disable forces pin low, undriven
// (RULE16) Analog control word goes out unchanged
// (RULE17) Hardware sync edge advances clock, no self-clear
// (RULE18) Prime data disable holds prime outputs low
// (RULE19) Scale word: step and cap, or factor
// (RULE20) Ramp rate paces scale counter in automatic mode
// (RULE21) Tuning word is the accumulator increment
// (RULE22) Phase offset added to accumulator output
// (RULE23) New tuning word acts after transfer strobe
// (RULE24) Step field encodes one, two, four, eight
`include "dcr_cfg.svh"
module dcr_top
	import dcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	output logic sdo_o,
	output logic sdo_oe,
	input wire logic io_update,
	input wire logic sync_in,
	input wire logic shaped_keying,
	input wire logic power_down_pin,
	output logic sync_clock_pin,
	output logic sync_clock_pin_oe,
	output logic [18:0] phase_word,
	output logic sine_sel,
	output logic amp_dither,
	output logic scale_bypass,
	output logic [13:0] scale_factor,
	output logic [23:0] analog_control,
	output logic dac_prime_en,
	output logic auto_sync_en,
	output logic digital_pd,
	output logic dac_digital_pd,
	output logic dac_pd,
	output logic clkin_pd,
	output logic pll_pd
);
	dcr_if bus();
	logic [6:0] pin_raw;
	logic [6:0] pin_s;
	logic sclk_s;
	logic cs_n_s;
	logic sdio_s;
	logic upd_s;
	logic sync_s;
	logic osk_s;
	logic pd_s;
	logic upd_d_r;
	logic sync_d_r;
	logic osk_d_r;
	logic upd_pulse;
	logic sync_rise;
	logic osk_chg;
	logic [31:0] primary_buf_r;
	logic [23:0] analog_buf_r;
	logic [15:0] scale_buf_r;
	logic [7:0] ramp_rate_buf_r;
	logic [31:0] freq_buf_r;
	logic [13:0] phase_buf_r;
	logic [31:0] primary_r;
	logic [23:0] analog_r;
	logic [15:0] scale_r;
	logic [7:0] ramp_rate_r;
	logic [31:0] freq_r;
	logic [13:0] phase_r;
	logic [31:0] acc_r;
	logic [7:0] tmr_r;
	logic [13:0] lvl_r;
	logic [1:0] div_r;
	logic [15:0] lfsr_r;
	logic [18:0] phase_word_r;
	logic [13:0] sf_r;
	logic bypass_r;
	logic dith_r;
	logic sync_clk_r;
	logic sync_oe_r;
	logic prime_en_r;
	logic [4:0] pd_r;
	logic wr_primary;
	logic wr_analog;
	logic wr_scale;
	logic wr_ramp;
	logic wr_freq;
	logic wr_phase;
	logic osk_en;
	logic osk_auto;
	logic halt;
	logic full_pd;
	logic sw_adv;
	logic hw_adv;
	logic ramp_run;
	logic ramp_step;
	logic tmr_load;
	logic [7:0] arr_load;
	logic [13:0] step;
	logic [14:0] up_sum;
	logic [13:0] lvl_nxt;
	logic [1:0] div_nxt;
	logic [31:0] phase_sum;
	logic [18:0] dither_mask;

	assign pin_raw = {power_down_pin, shaped_keying, sync_in, io_update, sdio_i, cs_n, sclk};
	dcr_sync2 #(.WIDTH(7)) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d(pin_raw),
		.q(pin_s)
	);
	assign sclk_s = pin_s[0];
	assign cs_n_s = pin_s[1];
	assign sdio_s = pin_s[2];
	assign upd_s = pin_s[3];
	assign sync_s = pin_s[4];
	assign osk_s = pin_s[5];
	assign pd_s = pin_s[6];

	dcr_serial u_serial (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.sclk_s(sclk_s),
		.cs_n_s(cs_n_s),
		.sdio_s(sdio_s),
		.sdio_o(sdio_o),
		.sdio_oe(sdio_oe),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe),
		.bus(bus.port)
	);

	// Register write decode and read-back of the staged values
	assign wr_primary = bus.wr_stb && (bus.addr == `DCR_ADDR_PRIMARY);
	assign wr_analog = bus.wr_stb && (bus.addr == `DCR_ADDR_ANALOG);
	assign wr_scale = bus.wr_stb && (bus.addr == `DCR_ADDR_SCALE);
	assign wr_ramp = bus.wr_stb && (bus.addr == `DCR_ADDR_RAMP);
	assign wr_freq = bus.wr_stb && (bus.addr == `DCR_ADDR_FREQ);
	assign wr_phase = bus.wr_stb && (bus.addr == `DCR_ADDR_PHASE);
	always_comb begin
		if (bus.addr == `DCR_ADDR_PRIMARY) begin
			bus.rdata = primary_buf_r;
		end else if (bus.addr == `DCR_ADDR_ANALOG) begin
			bus.rdata = {8'h00, analog_buf_r};
		end else if (bus.addr == `DCR_ADDR_SCALE) begin
			bus.rdata = {16'h0000, scale_buf_r};
		end else if (bus.addr == `DCR_ADDR_RAMP) begin
			bus.rdata = {24'h000000, ramp_rate_buf_r};
		end else if (bus.addr == `DCR_ADDR_FREQ) begin
			bus.rdata = freq_buf_r;
		end else if (bus.addr == `DCR_ADDR_PHASE) begin
			bus.rdata = {18'h00000, phase_buf_r};
		end else begin
			bus.rdata = 32'h00000000;
		end
	end
	// Serial format follows the transferred word, so a mode change lands between frames
	assign bus.three_wire = primary_r[`DCR_B_IN_ONLY]; // see (RULE10)
	assign bus.lsb_first = primary_r[`DCR_B_LSB_FIRST]; // see (RULE11)

	// Strobe and pin edges, from the second synchroniser flop only
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			upd_d_r <= 1'b0;
			sync_d_r <= 1'b0;
			osk_d_r <= 1'b0;
		end else begin
			upd_d_r <= upd_s;
			sync_d_r <= sync_s;
			osk_d_r <= osk_s;
		end
	end
	assign upd_pulse = upd_s & ~upd_d_r;
	assign sync_rise = sync_s & ~sync_d_r;
	assign osk_chg = osk_s ^ osk_d_r;

	// Staging registers; a host write wins over the self-clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			primary_buf_r <= `DCR_RST_PRIMARY;
		end else if (wr_primary) begin
			primary_buf_r <= bus.wdata;
		end else if (sw_adv) begin
			primary_buf_r[`DCR_B_SW_SYNC] <= 1'b0; // see (RULE5)
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			analog_buf_r <= `DCR_RST_ANALOG;
			scale_buf_r <= `DCR_RST_SCALE;
			ramp_rate_buf_r <= `DCR_RST_RAMP;
			freq_buf_r <= `DCR_RST_FREQ;
			phase_buf_r <= `DCR_RST_PHASE;
		end else begin
			if (wr_analog) analog_buf_r <= bus.wdata[23:0];
			if (wr_scale) scale_buf_r <= bus.wdata[15:0];
			if (wr_ramp) ramp_rate_buf_r <= bus.wdata[7:0];
			if (wr_freq) freq_buf_r <= bus.wdata;
			if (wr_phase) phase_buf_r <= bus.wdata[13:0];
		end
	end
	// Active registers load only on the transfer strobe; the software sync bit also self-clears
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			primary_r <= `DCR_RST_PRIMARY;
			analog_r <= `DCR_RST_ANALOG;
			scale_r <= `DCR_RST_SCALE;
			ramp_rate_r <= `DCR_RST_RAMP;
			freq_r <= `DCR_RST_FREQ;
			phase_r <= `DCR_RST_PHASE;
		end else if (upd_pulse) begin
			primary_r <= primary_buf_r;
			analog_r <= analog_buf_r;
			scale_r <= scale_buf_r;
			ramp_rate_r <= ramp_rate_buf_r;
			freq_r <= freq_buf_r; // see (RULE23)
			phase_r <= phase_buf_r;
		end else if (sw_adv) begin
			primary_r[`DCR_B_SW_SYNC] <= 1'b0; // see (RULE5)
		end
	end

	assign osk_en = primary_r[`DCR_B_OSK_EN];
	assign osk_auto = primary_r[`DCR_B_OSK_AUTO] & osk_en; // see (RULE3)
	assign full_pd = pd_s & primary_r[`DCR_B_PD_MODE];
	assign halt = primary_r[`DCR_B_DIG_PD] | pd_s; // see (RULE12)

	// Phase accumulator; clear has priority over power-down hold
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_r <= 32'h00000000;
		end else if (primary_r[`DCR_B_CLR_ACC]) begin
			acc_r <= 32'h00000000; // see (RULE9)
		end else if (upd_pulse && primary_buf_r[`DCR_B_AUTO_CLR] && !halt) begin
			acc_r <= 32'h00000000; // see (RULE7)
		end else if (!halt) begin
			acc_r <= acc_r + freq_r; // see (RULE21)
		end
	end

	// Phase offset lands on the top 14 bits; only the truncated field goes on
	assign phase_sum = acc_r + {phase_r, 18'h00000}; // see (RULE22)
	assign dither_mask = {15'h0000, primary_r[`DCR_B_PH_DITH_HI:`DCR_B_PH_DITH_LO] & lfsr_r[3:0]};
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lfsr_r <= `DCR_RST_LFSR;
			phase_word_r <= 19'h00000;
			dith_r <= 1'b0;
		end else if (!halt) begin
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
			phase_word_r <= phase_sum[31:13] ^ dither_mask; // see (RULE6)
			dith_r <= primary_r[`DCR_B_AMP_DITH] & lfsr_r[4]; // see (RULE6)
		end
	end

	// Ramp timer and automatic scale counter
	assign ramp_run = osk_auto & ~halt;
	assign ramp_step = ramp_run & (tmr_r == 8'h01);
	assign arr_load = upd_pulse ? ramp_rate_buf_r : ramp_rate_r;
	// Zero also reloads so an empty rate cannot wrap the timer
	assign tmr_load = (tmr_r <= 8'h01) | (upd_pulse & primary_buf_r[`DCR_B_RAMP_LOAD]) | osk_chg;
	assign step = 14'h0001 << scale_r[15:14]; // see (RULE24)
	assign up_sum = {1'b0, lvl_r} + {1'b0, step};
	always_comb begin
		if (osk_s) begin
			lvl_nxt = (up_sum > {1'b0, scale_r[13:0]}) ? scale_r[13:0] : up_sum[13:0]; // see (RULE19)
		end else begin
			lvl_nxt = (lvl_r < step) ? 14'h0000 : lvl_r - step;
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tmr_r <= `DCR_RST_RAMP;
			lvl_r <= 14'h0000;
		end else if (ramp_run) begin
			tmr_r <= tmr_load ? arr_load : tmr_r - 8'h01; // see (RULE1) (RULE20)
			if (ramp_step) lvl_r <= lvl_nxt;
		end
	end

	// Output scaling select
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bypass_r <= 1'b1;
			sf_r <= `DCR_SCALE_FULL;
		end else begin
			bypass_r <= ~osk_en; // see (RULE2)
			sf_r <= !osk_en ? `DCR_SCALE_FULL : (osk_auto ? lvl_r : scale_r[13:0]); // see (RULE19)
		end
	end

	// Sync clock runs at a quarter rate; an advance skips one phase step
	assign sw_adv = primary_r[`DCR_B_SW_SYNC]; // see (RULE5)
	assign hw_adv = analog_r[`DCR_B2_HW_SYNC] & sync_rise; // see (RULE17)
	assign div_nxt = div_r + ((sw_adv | hw_adv) ? `DCR_SYNC_ADV : `DCR_SYNC_STEP);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= 2'h0;
			sync_clk_r <= 1'b0;
			sync_oe_r <= 1'b1;
		end else begin
			div_r <= div_nxt;
			sync_clk_r <= div_nxt[1] & ~primary_r[`DCR_B_SYNC_DIS]; // see (RULE15)
			sync_oe_r <= ~primary_r[`DCR_B_SYNC_DIS]; // see (RULE15)
		end
	end

	// Power-down and analog-side controls
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_r <= 5'h00;
			prime_en_r <= 1'b0;
		end else begin
			pd_r[0] <= halt;
			pd_r[1] <= pd_s; // see (RULE14)
			pd_r[2] <= primary_r[`DCR_B_DAC_PD] | full_pd; // see (RULE13) (RULE14)
			pd_r[3] <= primary_r[`DCR_B_CLKIN_PD] | full_pd; // see (RULE13)
			pd_r[4] <= full_pd; // see (RULE14)
			prime_en_r <= ~analog_r[`DCR_B2_PRIME_DIS] & ~halt; // see (RULE18)
		end
	end

	assign phase_word = phase_word_r;
	assign sine_sel = primary_r[`DCR_B_SINE]; // see (RULE8)
	assign amp_dither = dith_r;
	assign scale_bypass = bypass_r;
	assign scale_factor = sf_r;
	assign analog_control = analog_r; // see (RULE16)
	assign dac_prime_en = prime_en_r;
	assign auto_sync_en = primary_r[`DCR_B_AUTO_SYNC]; // see (RULE4)
	assign sync_clock_pin = sync_clk_r;
	assign sync_clock_pin_oe = sync_oe_r;
	assign digital_pd = pd_r[0];
	assign dac_digital_pd = pd_r[1];
	assign dac_pd = pd_r[2];
	assign clkin_pd = pd_r[3];
	assign pll_pd = pd_r[4];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence sw_req_s;
		primary_r[`DCR_B_SW_SYNC] && !upd_pulse;
	endsequence
	sequence adv_seen_s;
		div_r == $past(div_r) + `DCR_SYNC_ADV;
	endsequence
	sync_sw_adv_a: assert property (sw_req_s |=> adv_seen_s ##0 !primary_r[`DCR_B_SW_SYNC]) // see (RULE5)
		else $error("software sync did not advance once and clear");
	sync_hw_adv_a: assert property (hw_adv |=> adv_seen_s ##0 analog_r[`DCR_B2_HW_SYNC]) // see (RULE17)
		else $error("hardware sync edge did not advance clock");
	ramp_reload_a: assert property (ramp_run && tmr_load |=> tmr_r == $past(arr_load)) // see (RULE1)
		else $error("ramp timer not reloaded");
	ramp_count_a: assert property (ramp_run && !tmr_load |=> tmr_r == $past(tmr_r) - 8'h01) // see (RULE20)
		else $error("ramp timer did not count down");
	scale_bypass_a: assert property (!osk_en |=> scale_bypass && scale_factor == 14'h3FFF) // see (RULE2)
		else $error("scaling not bypassed with keying off");
	manual_scale_a: assert property (osk_en && !osk_auto |=> scale_factor == $past(scale_r[13:0])) // see (RULE3)
		else $error("manual scale factor not applied");
	acc_autoclr_a: assert property (upd_pulse && primary_buf_r[`DCR_B_AUTO_CLR] && !halt |=> acc_r == 32'h00000000) // see (RULE7)
		else $error("auto-clear missed transfer strobe");
	acc_hold_a: assert property (primary_r[`DCR_B_CLR_ACC] [*2] |-> acc_r == 32'h00000000) // see (RULE9)
		else $error("accumulator not held clear");
	acc_step_a: assert property (!primary_r[`DCR_B_CLR_ACC] && !upd_pulse && !halt |=> acc_r == $past(acc_r) + $past(freq_r)) // see (RULE21)
		else $error("accumulator step is not the tuning word");
	sync_off_a: assert property (primary_r[`DCR_B_SYNC_DIS] |=> !sync_clock_pin && !sync_clock_pin_oe) // see (RULE15)
		else $error("sync clock pin not disabled");
endmodule

// file: test/dcr_host.sv
// Host model that programs the bank through its serial control port.
// Assumes ref_clk paces the bits, six cycles low and seven high per serial clock.
module dcr_host (
	input wire logic ref_clk,
	input wire logic lsb,
	input wire logic din,
	output logic sclk,
	output logic cs_n,
	output logic sdio_d
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdio_d = 1'b0;
	end
	// One frame: instruction byte, then n data bytes; reads fill d
	task automatic xfer(input logic rd, input logic [4:0] a, inout logic [31:0] d, input int n);
		logic [7:0] ins;
		int j;
		ins = {rd, 2'h0, a};
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (int i = 0; i < 8 + 8 * n; i++) begin
			j = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 8 * n + 7 - i);
			@(posedge ref_clk);
			sclk <= 1'b0;
			sdio_d <= (i < 8) ? ins[j] : d[j];
			// Read bit is settled well before the rise
			repeat (6) @(posedge ref_clk);
			if (rd && i >= 8) begin
				d[j] = din;
			end
			sclk <= 1'b1;
			repeat (6) @(posedge ref_clk);
		end
		cs_n <= 1'b1;
		sclk <= 1'b0;
		// Released line must not keep its last value
		sdio_d <= ~sdio_d;
		repeat (6) @(posedge ref_clk);
	endtask
endmodule

// file: test/test_dcr_top.sv
// Bench of the register bank: a table of control words, then edge cases.
// Assumes the host model for serial frames and one 125 MHz clock.
module test_dcr_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] pri; logic pin; logic [13:0] sf; logic [8:0] fl;} dcr_row_t;
	logic ref_clk, arst_n, sclk, cs_n, sdio_d, sdio_w, io_update, sync_in, shaped_keying;
	logic power_down_pin, sdio_o, sdio_oe, sdo_o, sdo_oe, sync_clock_pin, sync_clock_pin_oe;
	logic sine_sel, amp_dither, scale_bypass, dac_prime_en, auto_sync_en, digital_pd;
	logic dac_digital_pd, dac_pd, clkin_pd, pll_pd, lsb, three_wire, oe_seen, sdo_seen, sc_q;
	logic [18:0] phase_word, p0;
	logic [13:0] scale_factor;
	logic [23:0] analog_control;
	logic [8:0] fl_w;
	int bad_count, cmp_count, na, np, nb, s0, sc_adv;
	int sc_cnt = 4;
	dcr_row_t rows [9] = '{
		'{32'h00001000, 1'b0, 14'h3FFF, 9'b101000001},
		'{32'h00800000, 1'b0, 14'h3FFF, 9'b011000001},
		'{32'h02000000, 1'b0, 14'h1234, 9'b000000001},
		'{32'h01000000, 1'b0, 14'h3FFF, 9'b001000001},
		'{32'h000000A0, 1'b0, 14'h3FFF, 9'b001101001},
		'{32'h00000018, 1'b0, 14'h3FFF, 9'b001000101},
		'{32'h00000008, 1'b1, 14'h3FFF, 9'b001111111},
		'{32'h00000000, 1'b1, 14'h3FFF, 9'b001110001},
		'{32'h00000002, 1'b0, 14'h3FFF, 9'b001000000}};
	// Two-wire line: the bank wins while it drives
	assign sdio_w = sdio_oe ? sdio_o : sdio_d;
	assign fl_w = {sine_sel, auto_sync_en, scale_bypass, digital_pd, dac_digital_pd, dac_pd,
		clkin_pd, pll_pd, sync_clock_pin_oe};
	dcr_host host (.ref_clk(ref_clk), .lsb(lsb), .din(three_wire ? sdo_o : sdio_w),
		.sclk(sclk), .cs_n(cs_n), .sdio_d(sdio_d));
	dcr_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_w),
		.sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.io_update(io_update), .sync_in(sync_in), .shaped_keying(shaped_keying),
		.power_down_pin(power_down_pin), .sync_clock_pin(sync_clock_pin),
		.sync_clock_pin_oe(sync_clock_pin_oe), .phase_word(phase_word), .sine_sel(sine_sel),
		.amp_dither(amp_dither), .scale_bypass(scale_bypass), .scale_factor(scale_factor),
		.analog_control(analog_control), .dac_prime_en(dac_prime_en),
		.auto_sync_en(auto_sync_en), .digital_pd(digital_pd), .dac_digital_pd(dac_digital_pd),
		.dac_pd(dac_pd), .clkin_pd(clkin_pd), .pll_pd(pll_pd));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (three_wire ? sdio_oe : sdo_oe) begin
			oe_seen = 1'b1;
		end
		if (three_wire && sdo_oe) begin
			sdo_seen = 1'b1;
		end
	end
	// Rises come 4 cycles apart; each cycle missing is one advance
	always @(posedge ref_clk) begin
		sc_q <= sync_clock_pin;
		if (sync_clock_pin && !sc_q) begin
			sc_cnt <= 1;
			if (sc_cnt < 4) begin
				sc_adv <= sc_adv + 4 - sc_cnt;
			end
		end else begin
			sc_cnt <= sc_cnt + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v, input int n);
		logic [31:0] d;
		d = v;
		host.xfer(1'b0, a, d, n);
	endtask
	task automatic rc(input string nm, input logic [4:0] a, input int n, input logic [31:0] e);
		logic [31:0] v;
		v = 32'h0;
		host.xfer(1'b1, a, v, n);
		chk(nm, v, e);
	endtask
	task automatic upd();
		@(posedge ref_clk);
		io_update <= 1'b1;
		repeat (3) @(posedge ref_clk);
		io_update <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic sync_pulse();
		@(posedge ref_clk);
		sync_in <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sync_in <= 1'b0;
		repeat (16) @(posedge ref_clk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		arst_n = 1'b0;
		io_update = 1'b0;
		sync_in = 1'b0;
		shaped_keying = 1'b0;
		power_down_pin = 1'b0;
		lsb = 1'b0;
		three_wire = 1'b0;
		oe_seen = 1'b0;
		sdo_seen = 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("scale_factor", 32'(scale_factor), 32'h3FFF);
		chk("flags", 32'(fl_w), 32'h041);
		rc("amplitude_ramp_rate", 5'h3, 1, 0);
		wr(5'h2, 32'h1234, 2);
		foreach (rows[i]) begin
			power_down_pin <= rows[i].pin;
			wr(5'h0, rows[i].pri, 4);
			upd();
			chk("scale_factor", 32'(scale_factor), 32'(rows[i].sf));
			chk("flags", 32'(fl_w), 32'(rows[i].fl));
		end
		repeat (8) begin
			@(posedge ref_clk);
			chk("sync_clock_pin", 32'(sync_clock_pin), 0);
		end
		power_down_pin <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			wr(5'h1, k ? 32'h000100 : 32'h5AA05A, 3);
			upd();
			chk("analog_control", 32'(analog_control), k ? 32'h100 : 32'h5AA05A);
			chk("dac_prime_en", 32'(dac_prime_en), k ? 0 : 1);
		end
		wr(5'h0, 32'h0, 4);
		upd();
		wr(5'h4, 32'h2000, 4);
		p0 = phase_word;
		repeat (20) @(posedge ref_clk);
		chk("phase_word held", 32'(phase_word), 32'(p0));
		upd();
		p0 = phase_word;
		@(posedge ref_clk);
		chk("phase_word step", 32'(phase_word), 32'(p0 + 19'h1));
		wr(5'h0, 32'h2000, 4);
		upd();
		chk("phase_word cleared", 32'(phase_word < 19'd16), 1);
		wr(5'h0, 32'h400, 4);
		upd();
		repeat (10) @(posedge ref_clk);
		chk("phase_word held zero", 32'(phase_word), 0);
		wr(5'h5, 32'h0155, 2);
		upd();
		chk("phase_word offset", 32'(phase_word), 32'({14'h155, 5'h0}));
		wr(5'h0, 32'h001F0400, 4);
		upd();
		repeat (64) begin
			@(posedge ref_clk);
			na += (amp_dither === 1'b1);
			np += (phase_word[3:0] !== 4'h0);
			nb += (phase_word[18:4] !== 15'h2AA);
		end
		chk("amp_dither varies", 32'(na > 0 && na < 64 && np > 0 && nb == 0), 1);
		wr(5'h0, 32'h0, 4);
		upd();
		p0 = phase_word;
		@(posedge ref_clk);
		chk("phase_word resumes", 32'(phase_word), 32'(p0 + 19'h1));
		wr(5'h2, 32'hC00C, 2);
		wr(5'h3, 32'h04, 1);
		wr(5'h0, 32'h07000000, 4);
		upd();
		@(posedge ref_clk);
		shaped_keying <= 1'b1;
		for (int t = 0; t < 100 && scale_factor === 14'h0000; t++) begin
			@(posedge ref_clk);
		end
		chk("scale_factor first step", 32'(scale_factor), 32'h8);
		repeat (40) @(posedge ref_clk);
		chk("scale_factor capped", 32'(scale_factor), 32'hC);
		shaped_keying <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk("scale_factor ramped down", 32'(scale_factor), 0);
		s0 = sc_adv;
		wr(5'h0, 32'h00400000, 4);
		upd();
		rc("primary_control", 5'h0, 4, 0);
		chk("software sync advances", 32'(sc_adv - s0), 32'h1);
		wr(5'h6, 32'hFF, 1);
		rc("unmapped", 5'h6, 1, 0);
		rc("phase_offset", 5'h5, 2, 32'h0155);
		wr(5'h0, 32'h100, 4);
		upd();
		lsb <= 1'b1;
		rc("frequency_tuning", 5'h4, 4, 32'h2000);
		wr(5'h2, 32'h0ABC, 2);
		rc("amplitude_scale", 5'h2, 2, 32'h0ABC);
		wr(5'h0, 32'h300, 4);
		upd();
		three_wire <= 1'b1;
		rc("frequency_tuning", 5'h4, 4, 32'h2000);
		chk("sdio_oe in three-wire", 32'(oe_seen), 0);
		chk("sdo_oe in three-wire", 32'(sdo_seen), 1);
		s0 = sc_adv;
		sync_pulse();
		wr(5'h1, 32'h000400, 3);
		upd();
		sync_pulse();
		sync_pulse();
		chk("hardware sync advances", 32'(sc_adv - s0), 32'h2);
		chk("analog_control", 32'(analog_control), 32'h400);
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("scale_bypass", 32'(scale_bypass), 1);
		chk("analog_control in reset", 32'(analog_control), 0);
		arst_n <= 1'b1;
		lsb <= 1'b0;
		three_wire <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rc("primary_control", 5'h0, 4, 0);
		report_and_stop();
	end
endmodule
